// File: core/lcdsc_top.sv
// lcd segment/common driver: apb registers, frame timing, pin mapping
// assumes clock is the system oscillator, tick inputs are one-cycle
// pulses already synchronous to clock, apb master per the amba spec
//
// Contract
// [RQ1] contrast ladder open while module inactive
// [RQ2] three-bit tap select, 111 largest cut
// [RQ3] reference off, io supply or triple fvr
// [RQ4] reference forced off while inactive
// [RQ5] fvr buffer off in mode b with auto
// [RQ6] fvr enable requested automatically when needed
// [RQ7] three bias pins, independent enables
// [RQ8] common count select picks active commons
// [RQ9] active common pins ignore pin direction
// [RQ10] segment enable overrides pin direction
// [RQ11] segment enables clear after reset
// [RQ12] spare pixel bits are plain storage
// [RQ13] pixel index 3k plus s/8
// [RQ14] frame rate from k, commons, prescale, 32
// [RQ15] three selectable timing clock sources
// [RQ16] type a slice phase, type b frame phase
// [RQ17] dark pixel high rms, no dc
// [RQ18] sysosc clock halts immediately in sleep
// [RQ19] software sleeps only at zero dc
// [RQ20] interrupt when active goes inactive
// [RQ21] frame interrupt in type b
// [RQ22] 4-bit hidden prescaler, 1:1 to 1:16
// [RQ23] no frame interrupt type a or static
// [RQ24] blocked type b write sets error flag
// [RQ25] disable finishes frame, then inactive
// [RQ26] interrupt flag sticky until software clears
//
// Register access over APB and the register addresses were decided locally.
`include "lcdsc_params.svh"
module lcdsc_top
    import lcdsc_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic lfxo_tick,
    input wire logic lfio_tick,
    input wire logic sleep_req,
    input wire logic [3:0] com_pin_direction,
    input wire logic [23:0] seg_pin_direction,
    output logic [3:0][1:0] com_level,
    output logic [23:0][1:0] seg_level,
    output logic [3:0] com_lcd_own,
    output logic [3:0] com_oe,
    output logic [23:0] seg_lcd_own,
    output logic [23:0] seg_oe,
    output logic contrast_ladder_on,
    output logic [6:0] contrast_tap,
    output logic ref_io_on,
    output logic ref_fvr_on,
    output logic fvr_enable_req,
    output logic fvr_buffer_on,
    output logic [2:0] bias_pin_en,
    output logic [1:0] ladder_power,
    output logic lcd_irq
);
    lcdsc_state_s s_reg, s_next;
    lcdsc_apb_s bus;

    logic src_tick, base_tick, slice_end, frame_end, halted;
    logic in_a, wr_ok, mapped, wr_acc, rd_setup;
    logic shut_ev, frame_ev;
    logic [7:0] slice_len;
    logic [6:0] half_len, sub;
    logic [1:0] rsrc;
    logic [2:0] tap;
    logic [3:0] com_act;

    assign bus = '{psel, penable, pwrite, paddr, pwdata};
    assign pready = 1'b1;
    assign prdata = s_reg.rdata;
    assign wr_acc = bus.psel & bus.penable & bus.pwrite;
    assign rd_setup = bus.psel & ~bus.penable & ~bus.pwrite;

    always_comb begin
        mapped = 1'b1;
        if (bus.paddr == `LCDSC_OFF_CTRL) begin
            mapped = 1'b1;
        end else if (bus.paddr == `LCDSC_OFF_PRESC) begin
            mapped = 1'b1;
        end else if (bus.paddr == `LCDSC_OFF_BREF) begin
            mapped = 1'b1;
        end else if (bus.paddr == `LCDSC_OFF_LADDER) begin
            mapped = 1'b1;
        end else if (bus.paddr == `LCDSC_OFF_STAT) begin
            mapped = 1'b1;
        end else if (bus.paddr == `LCDSC_OFF_SEGEN) begin
            mapped = 1'b1;
        end else if (bus.paddr >= `LCDSC_OFF_PIX0 &&
                     bus.paddr <= `LCDSC_OFF_PIXN &&
                     bus.paddr[1:0] == 2'h0) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end
    assign pslverr = bus.psel & bus.penable & ~mapped;

    // [RQ15] timing clock source pick
    always_comb begin
        case (s_reg.csrc)
            `LCDSC_CS_SYS: src_tick = (s_reg.div == `LCDSC_SYS_DIV);
            `LCDSC_CS_XO: src_tick = lfxo_tick;
            `LCDSC_CS_IO: src_tick = lfio_tick;
            default: src_tick = 1'b0;
        endcase
    end

    // [RQ18] sysosc source stops on sleep
    assign halted = sleep_req &
        (s_reg.sleep_stop_select | (s_reg.csrc == `LCDSC_CS_SYS));

    // [RQ22] hidden prescaler divides source ticks
    assign base_tick = src_tick & (s_reg.pre == s_reg.ps) &
        (s_reg.st == LCDSC_RUN) & ~halted;

    // [RQ14] slice of k*32 base ticks per common
    always_comb begin
        case (s_reg.ccs)
            2'h0: slice_len = {1'b0, `LCDSC_BASE} << 2;
            2'h1: slice_len = {1'b0, `LCDSC_BASE} << 1;
            default: slice_len = {1'b0, `LCDSC_BASE};
        endcase
        half_len = slice_len[7:1];
    end
    // static slice of 128 needs the eighth bit
    assign slice_end = base_tick &
        ({1'b0, s_reg.cnt} == slice_len - 8'h01);
    assign frame_end = slice_end & (s_reg.common_line == s_reg.ccs);
    assign shut_ev = frame_end & ~s_reg.en;
    assign frame_ev = frame_end & s_reg.wtb & (s_reg.ccs != 2'h0) &
        s_reg.fphase;

    // [RQ5] ladder mode a just after each transition
    assign sub = (~s_reg.wtb && s_reg.cnt >= half_len) ?
        s_reg.cnt - half_len : s_reg.cnt;
    assign in_a = sub < {4'h0, s_reg.lad[`LCDSC_LD_ATIME +: 3]};

    // [RQ24] type b multiplexed writes only in the window
    assign wr_ok = ~(s_reg.act & s_reg.wtb & (s_reg.ccs != 2'h0)) |
        s_reg.wwin;

    always_comb begin
        s_next = s_reg;
        s_next.div = s_reg.div + 8'h01;
        if (src_tick && s_reg.st == LCDSC_RUN && !halted) begin
            s_next.pre = (s_reg.pre == s_reg.ps) ? 4'h0 :
                s_reg.pre + 4'h1;
        end
        if (base_tick) begin
            s_next.cnt = slice_end ? 7'h00 : s_reg.cnt + 7'h01;
        end
        if (slice_end) begin
            s_next.common_line = frame_end ? 2'h0 : s_reg.common_line + 2'h1;
            s_next.wwin = 1'b0;
        end
        case (s_reg.st)
            LCDSC_IDLE: begin
                if (s_reg.en) begin
                    s_next.st = LCDSC_RUN;
                    s_next.act = 1'b1;
                    s_next.cnt = 7'h00;
                    s_next.common_line = 2'h0;
                    s_next.pre = 4'h0;
                    s_next.fphase = 1'b0;
                end
            end
            LCDSC_RUN: begin
                if (halted) begin
                    s_next.st = LCDSC_HALT;
                end else if (frame_end) begin
                    // [RQ16] type b phase flips per frame
                    s_next.fphase = ~s_reg.fphase;
                    // [RQ21] frame irq on pair boundary
                    // [RQ23] none for type a or static
                    if (s_reg.wtb && s_reg.ccs != 2'h0 && s_reg.fphase) begin
                        s_next.f_frame = 1'b1;
                        s_next.wwin = 1'b1;
                    end
                    // [RQ25] shut down only at frame end
                    if (!s_reg.en) begin
                        s_next.st = LCDSC_IDLE;
                        s_next.act = 1'b0;
                        // [RQ20] active to inactive raises irq
                        s_next.f_shut = 1'b1;
                    end
                end
            end
            LCDSC_HALT: begin
                if (!sleep_req) begin
                    s_next.st = LCDSC_RUN;
                end
            end
            default: s_next.st = LCDSC_IDLE;
        endcase
        if (rd_setup) begin
            s_next.rdata = `LCDSC_RST_WORD;
            if (bus.paddr == `LCDSC_OFF_CTRL) begin
                s_next.rdata[8:0] = {s_reg.act, s_reg.write_blocked_flag, s_reg.en,
                    s_reg.sleep_stop_select, s_reg.wtb, s_reg.csrc, s_reg.ccs};
            end else if (bus.paddr == `LCDSC_OFF_PRESC) begin
                s_next.rdata[3:0] = s_reg.ps;
            end else if (bus.paddr == `LCDSC_OFF_BREF) begin
                s_next.rdata[10:0] = s_reg.bref;
            end else if (bus.paddr == `LCDSC_OFF_LADDER) begin
                s_next.rdata[7:0] = s_reg.lad & 8'hF7;
            end else if (bus.paddr == `LCDSC_OFF_STAT) begin
                s_next.rdata[1:0] = {s_reg.f_frame, s_reg.f_shut};
            end else if (bus.paddr == `LCDSC_OFF_SEGEN) begin
                s_next.rdata[23:0] = s_reg.seg_en;
            end else if (mapped) begin
                s_next.rdata[7:0] = s_reg.pix[bus.paddr[5:2]];
            end
        end
        if (wr_acc) begin
            if (bus.paddr == `LCDSC_OFF_CTRL) begin
                s_next.ccs = bus.pwdata[`LCDSC_CT_CCS +: 2];
                s_next.csrc = bus.pwdata[`LCDSC_CT_CSRC +: 2];
                s_next.wtb = bus.pwdata[`LCDSC_CT_WTB];
                s_next.sleep_stop_select = bus.pwdata[`LCDSC_CT_SLP];
                s_next.en = bus.pwdata[`LCDSC_CT_EN];
                if (bus.pwdata[`LCDSC_CT_WRITE_BLOCKED_FLAG]) begin
                    s_next.write_blocked_flag = 1'b0;
                end
            end else if (bus.paddr == `LCDSC_OFF_PRESC) begin
                s_next.ps = bus.pwdata[3:0];
            end else if (bus.paddr == `LCDSC_OFF_BREF) begin
                s_next.bref = bus.pwdata[10:0];
            end else if (bus.paddr == `LCDSC_OFF_LADDER) begin
                s_next.lad = bus.pwdata[7:0] & 8'hF7;
            end else if (bus.paddr == `LCDSC_OFF_STAT) begin
                // [RQ26] write one clears, new event wins
                if (bus.pwdata[`LCDSC_ST_SHUT] && !shut_ev) begin
                    s_next.f_shut = 1'b0;
                end
                if (bus.pwdata[`LCDSC_ST_FRAME] && !frame_ev) begin
                    s_next.f_frame = 1'b0;
                end
            end else if (bus.paddr == `LCDSC_OFF_SEGEN) begin
                s_next.seg_en = bus.pwdata[23:0];
            end else if (mapped) begin
                // [RQ12] spare pixel bits are stored like the used ones
                if (wr_ok) begin
                    s_next.pix[bus.paddr[5:2]] = bus.pwdata[7:0];
                end else begin
                    // [RQ24] blocked write flags error
                    s_next.write_blocked_flag = 1'b1;
                end
            end
        end
    end

    // [RQ11] all enables and pixel bits zero at reset
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '{st: LCDSC_IDLE, default: '0};
        end else begin
            s_reg <= s_next;
        end
    end

    // [RQ8] common count select gives active commons
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_com
            logic sel;
            logic ph;
            assign com_act[g] = s_reg.act && (g <= s_reg.ccs);
            assign sel = (s_reg.common_line == g);
            // [RQ16] type a halves the slice, type b per frame
            assign ph = s_reg.wtb ? s_reg.fphase : (s_reg.cnt >= half_len);
            // [RQ9] active common overrides pin direction
            assign com_lcd_own[g] = com_act[g];
            assign com_oe[g] = com_act[g] | ~com_pin_direction[g];
            assign com_level[g] = (!com_act[g] || s_reg.st == LCDSC_HALT &&
                s_reg.sleep_stop_select) ? 2'h0 :
                sel ? (ph ? 2'h3 : 2'h0) : (ph ? 2'h1 : 2'h2);
        end
        for (g = 0; g < 24; g = g + 1) begin : g_seg
            logic dark;
            logic ph;
            // [RQ13] byte 3k plus s/8, bit s mod 8
            assign dark = s_reg.pix[{2'h0, s_reg.common_line} * 4'h3 + g / 8][g % 8];
            assign ph = s_reg.wtb ? s_reg.fphase : (s_reg.cnt >= half_len);
            // [RQ10] segment enable overrides pin direction
            assign seg_lcd_own[g] = s_reg.seg_en[g];
            assign seg_oe[g] = s_reg.seg_en[g] | ~seg_pin_direction[g];
            // [RQ17] dark opposes common, clear sits near it
            assign seg_level[g] = (!s_reg.act || s_reg.st == LCDSC_HALT &&
                s_reg.sleep_stop_select) ? 2'h0 :
                dark ? (ph ? 2'h0 : 2'h3) : (ph ? 2'h2 : 2'h1);
        end
    endgenerate

    assign rsrc = s_reg.bref[`LCDSC_BR_SRC +: 2];
    assign tap = s_reg.bref[`LCDSC_BR_TAP +: 3];
    // [RQ3] selected source, only while active
    // [RQ4] inactive forces the reference off
    assign ref_io_on = s_reg.act & (rsrc == `LCDSC_RS_IO);
    assign ref_fvr_on = s_reg.act & (rsrc == `LCDSC_RS_FVR);
    // [RQ6] fvr request follows the bias need
    assign fvr_enable_req = ref_fvr_on;
    // [RQ5] buffer sleeps in ladder mode b when the auto bit is set
    assign fvr_buffer_on = ref_fvr_on &
        ~(s_reg.bref[`LCDSC_BR_AUTO] & ~in_a);
    // [RQ1] ladder closed only when active with a reference
    assign contrast_ladder_on = ref_io_on | ref_fvr_on;
    // [RQ2] tap n-1 for value n, zero leaves every tap open
    always_comb begin
        contrast_tap = 7'h00;
        if (contrast_ladder_on && tap != 3'h0) begin
            contrast_tap[tap - 3'h1] = 1'b1;
        end
    end
    // [RQ7] pin enables independent of the ladder
    assign bias_pin_en = s_reg.bref[`LCDSC_BR_VPIN +: 3];
    assign ladder_power = !s_reg.act ? 2'h0 : in_a ?
        s_reg.lad[`LCDSC_LD_APWR +: 2] : s_reg.lad[`LCDSC_LD_BPWR +: 2];
    // [RQ20] sticky flags drive the irq level
    assign lcd_irq = s_reg.f_shut | s_reg.f_frame;
endmodule

// File: core/lcdsc_params.svh
// register map, field positions and reset values of the lcd driver
// assumes a 32-bit apb slave with word-aligned registers
`ifndef LCDSC_PARAMS_SVH
`define LCDSC_PARAMS_SVH
`define LCDSC_OFF_CTRL 12'h000
`define LCDSC_OFF_PRESC 12'h004
`define LCDSC_OFF_BREF 12'h008
`define LCDSC_OFF_LADDER 12'h00C
`define LCDSC_OFF_STAT 12'h010
`define LCDSC_OFF_SEGEN 12'h014
`define LCDSC_OFF_PIX0 12'h040
`define LCDSC_OFF_PIXN 12'h06C
`define LCDSC_PIX_REGS 12
// control fields
`define LCDSC_CT_CCS 0
`define LCDSC_CT_CSRC 2
`define LCDSC_CT_WTB 4
`define LCDSC_CT_SLP 5
`define LCDSC_CT_EN 6
`define LCDSC_CT_WRITE_BLOCKED_FLAG 7
`define LCDSC_CT_ACT 8
// bias reference fields
`define LCDSC_BR_SRC 0
`define LCDSC_BR_AUTO 2
`define LCDSC_BR_VPIN 3
`define LCDSC_BR_TAP 8
// ladder fields
`define LCDSC_LD_ATIME 0
`define LCDSC_LD_BPWR 4
`define LCDSC_LD_APWR 6
// status fields
`define LCDSC_ST_SHUT 0
`define LCDSC_ST_FRAME 1
// clock sources and reference sources
`define LCDSC_CS_SYS 2'h0
`define LCDSC_CS_XO 2'h1
`define LCDSC_CS_IO 2'h2
`define LCDSC_RS_OFF 2'h0
`define LCDSC_RS_IO 2'h1
`define LCDSC_RS_FVR 2'h2
// timing
`define LCDSC_SYS_DIV 8'hFF
`define LCDSC_BASE 7'h20
`define LCDSC_HALF 7'h10
`define LCDSC_RST_WORD 32'h0
`endif

// File: core/lcdsc_pkg.sv
// types shared by the lcd segment/common driver
// assumes lcdsc_params.svh is in the include path
package lcdsc_pkg;
    typedef enum logic [1:0] {LCDSC_IDLE, LCDSC_RUN, LCDSC_HALT} lcdsc_st_e;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } lcdsc_apb_s;

    typedef struct packed {
        lcdsc_st_e st;
        logic [1:0] ccs;
        logic [1:0] csrc;
        logic wtb;
        logic sleep_stop_select;
        logic en;
        logic write_blocked_flag;
        logic act;
        logic [3:0] ps;
        logic [10:0] bref;
        logic [7:0] lad;
        logic [23:0] seg_en;
        logic [11:0][7:0] pix;
        logic f_shut;
        logic f_frame;
        logic [7:0] div;
        logic [3:0] pre;
        logic [6:0] cnt;
        logic [1:0] common_line;
        logic fphase;
        logic wwin;
        logic [31:0] rdata;
    } lcdsc_state_s;
endpackage

// File: bench/lcdsc_assertions.sv
// port checker for the lcd driver
// assumes a bind onto lcdsc_top, one clock domain
module lcdsc_assertions (
    input wire logic clock,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pslverr,
    input wire logic [3:0] com_pin_direction,
    input wire logic [23:0] seg_pin_direction,
    input wire logic [3:0] com_lcd_own,
    input wire logic [3:0] com_oe,
    input wire logic [23:0] seg_lcd_own,
    input wire logic [23:0] seg_oe,
    input wire logic contrast_ladder_on,
    input wire logic [6:0] contrast_tap,
    input wire logic ref_io_on,
    input wire logic ref_fvr_on,
    input wire logic fvr_enable_req,
    input wire logic fvr_buffer_on,
    input wire logic lcd_irq
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    ref_excl_a: assert property (!(ref_io_on && ref_fvr_on))
        else $error("both bias references on");
    ladder_ref_a: assert property (contrast_ladder_on |-> ref_io_on || ref_fvr_on)
        else $error("contrast ladder without reference");
    tap_onehot_a: assert property ($onehot0(contrast_tap))
        else $error("more than one contrast tap");
    fvr_req_a: assert property (ref_fvr_on |-> fvr_enable_req)
        else $error("fvr used but not requested");
    fvr_buffer_a: assert property (fvr_buffer_on |-> ref_fvr_on)
        else $error("fvr buffer on without fvr reference");
    com_dir_a: assert property (com_oe == (com_lcd_own | ~com_pin_direction))
        else $error("common pin drive wrong");
    seg_dir_a: assert property (seg_oe == (seg_lcd_own | ~seg_pin_direction))
        else $error("segment pin drive wrong");
    com_set_a: assert property (com_lcd_own inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF})
        else $error("common set not contiguous");
    err_phase_a: assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    rdata_hold_a: assert property (!(psel && !penable) |=> $stable(prdata))
        else $error("read data moved without setup");
    cover property (contrast_ladder_on);
    cover property (com_lcd_own == 4'hF);
    cover property (lcd_irq);
endmodule

bind lcdsc_top lcdsc_assertions chk (.clock, .nrst, .psel, .penable,
    .prdata, .pslverr, .com_pin_direction, .seg_pin_direction,
    .com_lcd_own, .com_oe, .seg_lcd_own, .seg_oe, .contrast_ladder_on,
    .contrast_tap, .ref_io_on, .ref_fvr_on, .fvr_enable_req,
    .fvr_buffer_on, .lcd_irq);

// File: bench/lcdsc_glass.sv
// glass model: net dc of the pixel on common 0 and segment 0
// assumes levels settle before each rising edge
module lcdsc_glass (
    input wire logic clock,
    input wire logic nrst,
    input wire logic sample,
    input wire logic clear,
    input wire logic own,
    input wire logic [1:0] com_lvl,
    input wire logic [1:0] seg_lvl,
    output int dc_sum
);
    timeunit 1ns;
    timeprecision 1ns;
    // pixel net dc
    // summed per timing tick so clock ratio adds no bias
    always @(posedge clock or negedge nrst) begin
        if (!nrst || clear) begin
            dc_sum <= 0;
        end else if (sample && own) begin
            dc_sum <= dc_sum + int'(com_lvl) - int'(seg_lvl);
        end
    end
endmodule

// File: bench/tb_top.sv
// self-checking bench for the lcd driver over apb
// assumes lcdsc_params.svh on the include path
`include "lcdsc_params.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [11:0] CT = `LCDSC_OFF_CTRL;
    localparam logic [11:0] ST = `LCDSC_OFF_STAT;
    localparam logic [11:0] PX = `LCDSC_OFF_PIX0;
    // enabled, internal low-freq clock
    localparam logic [31:0] RUN = 32'h48;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic lfio_tick = 1'b0, sleep_req = 1'b0, gclr = 1'b0, last_err;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    logic [23:0] seg_dir = 24'hFFFFFF, seg_lcd_own, seg_oe;
    logic [3:0][1:0] com_level;
    logic [23:0][1:0] seg_level;
    logic [3:0] com_lcd_own, com_oe;
    logic [6:0] contrast_tap;
    logic [2:0] bias_pin_en;
    logic [1:0] ladder_power;
    logic pready, pslverr, contrast_ladder_on, ref_io_on, ref_fvr_on;
    logic fvr_enable_req, fvr_buffer_on, lcd_irq;
    int err_count = 0, check_count = 0, cyc = 0, dc;

    lcdsc_top dut (.clock, .nrst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lfxo_tick(1'b0), .lfio_tick,
        .sleep_req, .com_pin_direction(4'hF), .seg_pin_direction(seg_dir),
        .com_level, .seg_level, .com_lcd_own, .com_oe, .seg_lcd_own,
        .seg_oe, .contrast_ladder_on, .contrast_tap, .ref_io_on,
        .ref_fvr_on, .fvr_enable_req, .fvr_buffer_on, .bias_pin_en,
        .ladder_power, .lcd_irq);
    lcdsc_glass glass (.clock, .nrst, .sample(lfio_tick), .clear(gclr),
        .own(com_lcd_own[0]), .com_lvl(com_level[0]),
        .seg_lvl(seg_level[0]), .dc_sum(dc));

    always #10 clock = ~clock;
    // tick every fourth cycle keeps frames short
    always @(posedge clock) begin
        cyc <= cyc + 1;
        lfio_tick <= (cyc % 4 == 3);
        if (cyc == 40000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // one apb transfer; the short wait lets register updates land
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1) @(posedge clock);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    task automatic wait_off();
        rd = 32'hFFFFFFFF;
        for (int i = 0; i < 600 && rd[`LCDSC_CT_ACT] !== 1'b0; i++) begin
            apb(1'b0, CT, 32'h0);
        end
    endtask

    task automatic s_regs();
        apb(1'b0, `LCDSC_OFF_SEGEN, 32'h0);
        chk(rd, 32'h0, "segen reset");
        apb(1'b1, 12'h020, 32'hFFFFFFFF);
        apb(1'b0, 12'h020, 32'h0);
        chk({rd[30:0], last_err}, 32'h1, "unmapped");
        for (int i = 0; i < 12; i++) begin
            apb(1'b1, PX + 12'(4 * i), 32'hFFFFFF00 | 32'(i * 17));
        end
        for (int i = 0; i < 12; i++) begin
            apb(1'b0, PX + 12'(4 * i), 32'h0);
            chk(rd, 32'(i * 17), "pixel store");
        end
    endtask

    task automatic s_common();
        seg_dir <= 24'h00FFFF;
        apb(1'b1, `LCDSC_OFF_SEGEN, 32'h00A5A5A5);
        apb(1'b1, `LCDSC_OFF_BREF, 32'h729);
        chk(32'(contrast_ladder_on), 32'h0, "ladder idle");
        chk(32'(ref_io_on), 32'h0, "ref idle");
        for (int c = 0; c < 4; c++) begin
            apb(1'b1, CT, RUN | 32'(c));
            repeat (2) @(posedge clock);
            #1;
            chk(32'(com_lcd_own), 32'((2 << c) - 1), "commons");
            chk(32'(com_oe), 32'((2 << c) - 1), "common oe");
        end
        chk(32'(contrast_ladder_on), 32'h1, "ladder on");
        chk(32'(contrast_tap), 32'h40, "tap");
        chk(32'(ref_io_on), 32'h1, "ref io");
        chk(32'(bias_pin_en), 32'h5, "bias pins");
        chk(32'(seg_lcd_own), 32'hA5A5A5, "seg own");
        chk(32'(seg_oe), 32'hFFA5A5, "seg oe");
    endtask

    task automatic s_shut();
        apb(1'b1, CT, 32'h0B);
        wait_off();
        apb(1'b0, ST, 32'h0);
        chk(rd, 32'h1, "shutdown only");
        chk(32'(lcd_irq), 32'h1, "irq set");
        chk(32'(contrast_ladder_on), 32'h0, "ladder off");
        apb(1'b1, ST, 32'h1);
        chk(32'(lcd_irq), 32'h0, "irq clear");
        gclr <= 1'b1;
        apb(1'b1, CT, RUN | 32'h3);
        gclr <= 1'b0;
        repeat (1300) @(posedge clock);
        apb(1'b1, CT, 32'h0B);
        apb(1'b0, CT, 32'h0);
        chk(32'(rd[`LCDSC_CT_ACT]), 32'h1, "frame finishing");
        wait_off();
        chk(32'(dc), 32'h0, "pixel dc");
        apb(1'b0, ST, 32'h0);
        chk(rd, 32'h1, "flag again");
        apb(1'b1, ST, 32'h3);
    endtask

    task automatic s_sleep();
        sleep_req <= 1'b1; // sleep held while the module is enabled
        apb(1'b1, CT, 32'h63);
        repeat (4) @(posedge clock);
        #1;
        chk(32'(com_level), 32'h0, "sleep drives vss");
        apb(1'b1, CT, 32'h43);
        repeat (4200) @(posedge clock);
        #1;
        chk(32'(com_level), 32'hA8, "sysosc held");
        apb(1'b1, CT, 32'h0B);
        sleep_req <= 1'b0;
        wait_off();
        chk(32'(rd[`LCDSC_CT_ACT]), 32'h0, "off after wake");
        apb(1'b1, ST, 32'h1);
    endtask

    task automatic s_typeb();
        apb(1'b1, CT, RUN | 32'h13);
        apb(1'b1, PX, 32'hEE);
        apb(1'b0, PX, 32'h0);
        chk(rd, 32'h0, "blocked write");
        apb(1'b0, CT, 32'h0);
        chk(32'(rd[`LCDSC_CT_WRITE_BLOCKED_FLAG]), 32'h1, "error flag");
        apb(1'b1, CT, RUN | 32'h93);
        rd = 32'h0;
        for (int i = 0; i < 1000 && rd[1] !== 1'b1; i++) begin
            apb(1'b0, ST, 32'h0);
        end
        chk(32'(rd[1]), 32'h1, "frame flag");
        apb(1'b1, PX, 32'h77);
        apb(1'b0, PX, 32'h0);
        chk(rd, 32'h77, "window write");
        apb(1'b1, CT, 32'h0);
    endtask

    task automatic complete_run();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        s_regs();
        s_common();
        s_shut();
        s_sleep();
        s_typeb();
        complete_run();
    end
endmodule
